// file: core/eag_top.sv
/*
  eag_top: effective-address generator for the 32-bit core.
  Assumes the decoder presents one request per req_valid cycle on clk, with
  register values already read. Results appear one cycle later, registered.
*/
`timescale 1ns/1ps
`default_nettype none
module eag_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire eag_pkg::eag_req_s req,
  input wire logic translation_enable_bit,
  input wire logic single_space_mode_bit,
  input wire logic [31:0] page_entry_high_register,
  output logic rsp_valid,
  output eag_pkg::eag_rsp_s rsp
);
  import eag_pkg::*;

  logic [31:0] step;
  logic [31:0] disp4_scaled;
  logic [31:0] disp8_scaled;
  logic [31:0] pc_scaled;
  logic [31:0] pc_base;
  logic [31:0] pc_plus4;
  logic [31:0] br8_ext;
  logic [31:0] br12_ext;
  eag_rsp_s next_rsp;

  function automatic logic [31:0] size_step(input eag_size_e sz);
    unique case (sz)
      EAG_SZ_BYTE: size_step = 32'h0000_0001;
      EAG_SZ_WORD: size_step = 32'h0000_0002;
      EAG_SZ_LONG: size_step = 32'h0000_0004;
      EAG_SZ_QUAD: size_step = 32'h0000_0008;
    endcase
  endfunction

  assign step = size_step(req.size);

  eag_scale u_scale_d4 (
    .disp({8'h00, req.disp[EAG_DISP4_W-1:0]}),
    .size(req.size),
    .allow_byte(1'b1),
    .scaled(disp4_scaled)
  );

  // 8-bit displacement off the global base
  eag_scale u_scale_d8 (
    .disp({4'h0, req.disp[EAG_DISP8_W-1:0]}),
    .size(req.size),
    .allow_byte(1'b1),
    .scaled(disp8_scaled)
  );

  // pc loads scale by 2 or 4 only
  eag_scale u_scale_pc (
    .disp({4'h0, req.disp[EAG_DISP8_W-1:0]}),
    .size(req.size),
    .allow_byte(1'b0),
    .scaled(pc_scaled)
  );

  // pc is that of the instruction being executed
  assign pc_plus4 = req.pc + EAG_PC_OFFSET;
  // longword masks pc low two bits before adding 4
  assign pc_base = (req.size == EAG_SZ_LONG) ? ((req.pc & EAG_LONG_MASK) + EAG_PC_OFFSET)
                                             : pc_plus4;
  // sign-extended short branch displacement times 2
  assign br8_ext = {{23{req.disp[EAG_DISP8_W-1]}}, req.disp[EAG_DISP8_W-1:0], 1'b0};
  // sign-extended long branch displacement times 2
  assign br12_ext = {{19{req.disp[EAG_DISP12_W-1]}}, req.disp[EAG_DISP12_W-1:0], 1'b0};

  // every sum below is 32 bits wide; carries fall off
  always_comb
  begin
    next_rsp = '0;
    unique case (req.mode)
      EAG_M_REG_DIRECT:
      begin
        next_rsp.operand = req.sel_reg;
        next_rsp.operand_valid = 1'b1;
      end
      EAG_M_REG_IND:
      begin
        next_rsp.effective_address = req.sel_reg;
        next_rsp.addr_valid = 1'b1;
      end
      EAG_M_POST_INC:
      begin
        // old value addresses, increment written back
        next_rsp.effective_address = req.sel_reg;
        next_rsp.addr_valid = 1'b1;
        next_rsp.writeback_value = req.sel_reg + step;
        next_rsp.writeback_en = 1'b1;
      end
      EAG_M_PRE_DEC:
      begin
        // decremented value addresses and is written back
        next_rsp.effective_address = req.sel_reg - step;
        next_rsp.addr_valid = 1'b1;
        next_rsp.writeback_value = req.sel_reg - step;
        next_rsp.writeback_en = 1'b1;
      end
      EAG_M_REG_DISP:
      begin
        next_rsp.effective_address = req.sel_reg + disp4_scaled;
        next_rsp.addr_valid = 1'b1;
      end
      EAG_M_IDX_REG:
      begin
        next_rsp.effective_address = req.sel_reg + req.index_reg_zero;
        next_rsp.addr_valid = 1'b1;
      end
      EAG_M_GBR_DISP:
      begin
        next_rsp.effective_address = req.global_base_reg + disp8_scaled;
        next_rsp.addr_valid = 1'b1;
      end
      EAG_M_IDX_GBR:
      begin
        // global base plus index register zero
        next_rsp.effective_address = req.global_base_reg + req.index_reg_zero;
        next_rsp.addr_valid = 1'b1;
      end
      EAG_M_PC_DISP:
      begin
        next_rsp.effective_address = pc_base + pc_scaled;
        next_rsp.addr_valid = 1'b1;
      end
      EAG_M_BR_SHORT:
      begin
        next_rsp.effective_address = pc_plus4 + br8_ext;
        next_rsp.addr_valid = 1'b1;
        next_rsp.is_branch = 1'b1;
      end
      EAG_M_BR_LONG:
      begin
        next_rsp.effective_address = pc_plus4 + br12_ext;
        next_rsp.addr_valid = 1'b1;
        next_rsp.is_branch = 1'b1;
      end
      EAG_M_BR_REG:
      begin
        next_rsp.effective_address = pc_plus4 + req.sel_reg;
        next_rsp.addr_valid = 1'b1;
        next_rsp.is_branch = 1'b1;
      end
      EAG_M_IMM_ZERO:
      begin
        next_rsp.imm_ext = {24'h000000, req.imm};
      end
      EAG_M_IMM_SIGN:
      begin
        next_rsp.imm_ext = {{24{req.imm[EAG_IMM_W-1]}}, req.imm};
      end
      EAG_M_IMM_TRAP:
      begin
        // trap vector offset, imm times 4
        next_rsp.imm_ext = {22'h0, req.imm, 2'h0};
      end
      default:
      begin
        next_rsp = '0;
      end
    endcase
    // addresses go to translation while it is enabled
    next_rsp.translate = next_rsp.addr_valid & translation_enable_bit;
    // multiple-space mode attaches the space identifier to translated addresses
    if (next_rsp.translate && !single_space_mode_bit)
    begin
      next_rsp.address_space_identifier = page_entry_high_register[EAG_ADDRESS_SPACE_IDENTIFIER_W-1:0];
      next_rsp.address_space_identifier_valid = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      rsp_valid <= 1'b0;
    else
      rsp_valid <= req_valid;
  end

  // data held when idle; control flags cleared so no stale writeback
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      rsp <= '0;
    else if (req_valid)
      rsp <= next_rsp;
    else
    begin
      rsp.writeback_en <= 1'b0;
      rsp.addr_valid <= 1'b0;
      rsp.operand_valid <= 1'b0;
      rsp.translate <= 1'b0;
      rsp.address_space_identifier_valid <= 1'b0;
      rsp.is_branch <= 1'b0;
    end
  end
endmodule // eag_top
`default_nettype wire

// file: core/eag_pkg.sv
/*
  eag_pkg: shared types and constants for the effective-address generator.
  Assumes a single core clock domain; the decoder and MMU sit on the same clock.
*/
// Overview of operation
// - with translation enabled, every address is sent on for translation
// - translation on, single-space bit clear: supply low part of page entry high as space id
// - register direct: selected register is the operand, no address formed
// - register indirect: selected register value is the address
// - post-increment: address is register, then add 1/2/4/8 by size
// - pre-decrement: subtract 1/2/4/8, write back, use decremented value
// - 4-bit displacement zero-extended, scaled 1/2/4, added to register
// - indexed indirect: register plus index register zero
// - 8-bit displacement zero-extended, scaled 1/2/4, added to global base
// - indexed global base: global base plus index register zero
// - pc load: zero-extend disp, scale 2/4, add pc+4, long masks pc low bits
// - short branch: sign-extend 8-bit disp, times 2, add pc+4
// - long branch: sign-extend 12-bit disp, times 2, add pc+4
// - register branch: pc+4 plus selected register
// - bit-test, and, or, xor immediates are zero-extended
// - move, add, compare-equal immediates are sign-extended
// - trap immediate zero-extended and multiplied by 4
// - pc used is the address of the executing instruction
package eag_pkg;

  localparam int unsigned EAG_XLEN = 32;
  localparam int unsigned EAG_ADDRESS_SPACE_IDENTIFIER_W = 8;
  localparam logic [31:0] EAG_PC_OFFSET = 32'h0000_0004;
  localparam logic [31:0] EAG_LONG_MASK = 32'hffff_fffc;
  localparam int unsigned EAG_DISP4_W = 4;
  localparam int unsigned EAG_DISP8_W = 8;
  localparam int unsigned EAG_DISP12_W = 12;
  localparam int unsigned EAG_IMM_W = 8;
  localparam int unsigned EAG_TRAP_SHIFT = 2;

  typedef enum logic [1:0] {
    EAG_SZ_BYTE = 2'h0,
    EAG_SZ_WORD = 2'h1,
    EAG_SZ_LONG = 2'h2,
    EAG_SZ_QUAD = 2'h3
  } eag_size_e;

  typedef enum logic [3:0] {
    EAG_M_REG_DIRECT = 4'h0,
    EAG_M_REG_IND = 4'h1,
    EAG_M_POST_INC = 4'h2,
    EAG_M_PRE_DEC = 4'h3,
    EAG_M_REG_DISP = 4'h4,
    EAG_M_IDX_REG = 4'h5,
    EAG_M_GBR_DISP = 4'h6,
    EAG_M_IDX_GBR = 4'h7,
    EAG_M_PC_DISP = 4'h8,
    EAG_M_BR_SHORT = 4'h9,
    EAG_M_BR_LONG = 4'ha,
    EAG_M_BR_REG = 4'hb,
    EAG_M_IMM_ZERO = 4'hc,
    EAG_M_IMM_SIGN = 4'hd,
    EAG_M_IMM_TRAP = 4'he
  } eag_mode_e;

  // one decoded operand request from the instruction decoder
  typedef struct packed {
    eag_mode_e mode;
    eag_size_e size;
    logic [11:0] disp;
    logic [7:0] imm;
    logic [31:0] sel_reg;
    logic [31:0] index_reg_zero;
    logic [31:0] global_base_reg;
    logic [31:0] pc;
  } eag_req_s;

  // registered result toward the pipeline and the translation unit
  typedef struct packed {
    logic [31:0] effective_address;
    logic addr_valid;
    logic is_branch;
    logic [31:0] operand;
    logic operand_valid;
    logic [31:0] writeback_value;
    logic writeback_en;
    logic [31:0] imm_ext;
    logic translate;
    logic [7:0] address_space_identifier;
    logic address_space_identifier_valid;
  } eag_rsp_s;

endpackage

// file: core/eag_scale.sv
/*
  eag_scale: shifts a zero-extended displacement by operand size.
  Assumes purely combinational use inside the address generator.
*/
`timescale 1ns/1ps
`default_nettype none
module eag_scale (
  input wire logic [11:0] disp,
  input wire eag_pkg::eag_size_e size,
  input wire logic allow_byte,
  output logic [31:0] scaled
);
  import eag_pkg::*;

  logic [31:0] wide;

  assign wide = {20'h00000, disp};

  always_comb
  begin
    unique case (size)
      EAG_SZ_BYTE: scaled = allow_byte ? wide : {wide[30:0], 1'b0};
      EAG_SZ_WORD: scaled = {wide[30:0], 1'b0};
      EAG_SZ_LONG: scaled = {wide[29:0], 2'h0};
      // quadword has no displacement form; treated as longword scale
      EAG_SZ_QUAD: scaled = {wide[29:0], 2'h0};
    endcase
  end
endmodule // eag_scale
`default_nettype wire

// file: sim/eag_dec_model.sv
/*
  eag_dec_model: decoder-side partner that presents requests.
  Assumes the bench raises issue with nreq just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module eag_dec_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic issue,
  input wire eag_pkg::eag_req_s nreq,
  output logic req_valid,
  output eag_pkg::eag_req_s req
);
  import eag_pkg::*;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      req_valid <= 1'b0;
      req <= '0;
    end
    else
    begin
      req_valid <= issue;
      // idle fields toggle so stale values never look valid
      req <= issue ? nreq : ~req;
    end
  end
endmodule // eag_dec_model
`default_nettype wire

// file: sim/eag_top_asserts.sv
/*
  eag_top_asserts: checker on the ports of eag_top.
  Assumes one clock domain and a registered answer one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
module eag_top_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire eag_pkg::eag_req_s req,
  input wire logic translation_enable_bit,
  input wire logic single_space_mode_bit,
  input wire logic [31:0] page_entry_high_register,
  input wire logic rsp_valid,
  input wire eag_pkg::eag_rsp_s rsp
);
  import eag_pkg::*;
  eag_req_s q;
  logic qt;
  logic qs;
  logic [7:0] qa;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      q <= '0;
      qt <= 1'b0;
      qs <= 1'b0;
      qa <= 8'h00;
    end
    else
    begin
      q <= req;
      qt <= translation_enable_bit;
      qs <= single_space_mode_bit;
      qa <= page_entry_high_register[7:0];
    end
  end
  rsp_lat_a: assert property (rsp_valid == $past(req_valid)) else $error("bad latency");
  reg_direct_a: assert property (rsp_valid && q.mode == EAG_M_REG_DIRECT |->
    rsp.operand == q.sel_reg && rsp.operand_valid && !rsp.addr_valid) else $error("direct");
  reg_ind_a: assert property (rsp_valid && q.mode == EAG_M_REG_IND |->
    rsp.effective_address == q.sel_reg) else $error("indirect");
  post_inc_a: assert property (rsp_valid && q.mode == EAG_M_POST_INC |->
    rsp.effective_address == q.sel_reg && rsp.writeback_en &&
    rsp.writeback_value == q.sel_reg + (32'h1 << q.size)) else $error("post inc");
  pre_dec_a: assert property (rsp_valid && q.mode == EAG_M_PRE_DEC |->
    rsp.effective_address == q.sel_reg - (32'h1 << q.size) && rsp.writeback_en &&
    rsp.writeback_value == rsp.effective_address) else $error("pre dec");
  idx_sum_a: assert property (rsp_valid && q.mode == EAG_M_IDX_REG |->
    rsp.effective_address == q.sel_reg + q.index_reg_zero) else $error("index");
  br_short_a: assert property (rsp_valid && q.mode == EAG_M_BR_SHORT |->
    rsp.effective_address == q.pc + 32'h4 + {{23{q.disp[7]}}, q.disp[7:0], 1'b0})
    else $error("short branch");
  xlat_on_a: assert property (rsp_valid |->
    rsp.translate == (rsp.addr_valid && qt)) else $error("translate");
  address_space_identifier_out_a: assert property (rsp_valid && rsp.translate && !qs |->
    rsp.address_space_identifier_valid && rsp.address_space_identifier == qa) else $error("space id");
  // stale flags between requests would replay a writeback or a translation
  flags_idle_a: assert property (!rsp_valid |->
    !(rsp.addr_valid || rsp.writeback_en || rsp.operand_valid || rsp.translate ||
    rsp.address_space_identifier_valid || rsp.is_branch)) else $error("flags idle");
  cover property (rsp_valid && rsp.writeback_en);
  cover property (rsp_valid && rsp.address_space_identifier_valid);
  cover property (rsp_valid && rsp.is_branch);
endmodule // eag_top_asserts
bind eag_top eag_top_asserts eag_top_asserts_inst (.clk(clk), .sys_rst(sys_rst),
  .req_valid(req_valid), .req(req), .translation_enable_bit(translation_enable_bit),
  .single_space_mode_bit(single_space_mode_bit),
  .page_entry_high_register(page_entry_high_register), .rsp_valid(rsp_valid), .rsp(rsp));
`default_nettype wire

// file: sim/effective_address_generator_tb.sv
/*
  effective_address_generator_tb: self-checking bench for eag_top.
  Assumes the partner adds one cycle ahead of the design.
*/
`timescale 1ns/1ps
`default_nettype none
module effective_address_generator_tb;
  import eag_pkg::*;
  logic clk, sys_rst, issue, te, ssm, req_valid, rsp_valid;
  logic [31:0] pehr;
  eag_req_s nreq, r, req;
  eag_rsp_s rsp;
  int failures, checks;
  always #2 clk = ~clk;
  eag_dec_model eag_dec_model_inst (.clk(clk), .sys_rst(sys_rst), .issue(issue),
    .nreq(nreq), .req_valid(req_valid), .req(req));
  eag_top eag_top_inst (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req(req),
    .translation_enable_bit(te), .single_space_mode_bit(ssm),
    .page_entry_high_register(pehr), .rsp_valid(rsp_valid), .rsp(rsp));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task go(input eag_mode_e m, input int s, input logic [11:0] d, input logic [31:0] a);
    r.mode = m;
    r.size = eag_size_e'(s);
    r.disp = d;
    r.sel_reg = a;
    @(posedge clk);
    issue <= 1'b1;
    nreq <= r;
    @(posedge clk);
    issue <= 1'b0;
    @(posedge clk);
    #1;
    chk(rsp_valid, 32'h1);
  endtask
  task t_basic;
    r.index_reg_zero = 32'h0000_0020;
    r.global_base_reg = 32'h8000_0000;
    go(EAG_M_REG_DIRECT, 2, 12'h0, 32'h1234_5678);
    chk(rsp.operand, 32'h1234_5678);
    chk(rsp.addr_valid, 32'h0);
    chk(rsp.operand_valid, 32'h1);
    go(EAG_M_REG_IND, 2, 12'h0, 32'h0000_0abc);
    chk(rsp.effective_address, 32'h0000_0abc);
    chk(rsp.writeback_en, 32'h0);
    go(EAG_M_IDX_REG, 2, 12'h0, 32'hffff_fff0);
    chk(rsp.effective_address, 32'h0000_0010);
    go(EAG_M_IDX_GBR, 2, 12'h0, 32'h0);
    chk(rsp.effective_address, 32'h8000_0020);
    $display("done basic");
  endtask
  task t_step;
    for (int s = 0; s < 4; s++)
    begin
      go(EAG_M_POST_INC, s, 12'h0, 32'hffff_fffc);
      chk(rsp.effective_address, 32'hffff_fffc);
      chk(rsp.writeback_value, 32'hffff_fffc + (32'h1 << s));
      chk(rsp.writeback_en, 32'h1);
      go(EAG_M_PRE_DEC, s, 12'h0, 32'h0000_0004);
      chk(rsp.effective_address, 32'h0000_0004 - (32'h1 << s));
      chk(rsp.writeback_value, 32'h0000_0004 - (32'h1 << s));
      chk(rsp.writeback_en, 32'h1);
    end
    for (int s = 0; s < 3; s++)
    begin
      go(EAG_M_REG_DISP, s, 12'hfff, 32'h0000_0100);
      chk(rsp.effective_address, 32'h0000_0100 + (32'hf << s));
      go(EAG_M_GBR_DISP, s, 12'hfff, 32'h0);
      chk(rsp.effective_address, 32'h8000_0000 + (32'hff << s));
    end
    $display("done step");
  endtask
  task t_pc;
    r.pc = 32'h0000_1002;
    go(EAG_M_PC_DISP, 1, 12'h0ff, 32'h0);
    chk(rsp.effective_address, 32'h0000_1204);
    go(EAG_M_PC_DISP, 2, 12'h0ff, 32'h0);
    chk(rsp.effective_address, 32'h0000_1400);
    go(EAG_M_BR_SHORT, 2, 12'h080, 32'h0);
    chk(rsp.effective_address, 32'h0000_0f06);
    chk(rsp.is_branch, 32'h1);
    go(EAG_M_BR_LONG, 2, 12'h800, 32'h0);
    chk(rsp.effective_address, 32'h0000_0006);
    go(EAG_M_BR_REG, 2, 12'h0, 32'hffff_fffa);
    chk(rsp.effective_address, 32'h0000_1000);
    r.imm = 8'h80;
    go(EAG_M_IMM_ZERO, 2, 12'h0, 32'h0);
    chk(rsp.imm_ext, 32'h0000_0080);
    go(EAG_M_IMM_SIGN, 2, 12'h0, 32'h0);
    chk(rsp.imm_ext, 32'hffff_ff80);
    go(EAG_M_IMM_TRAP, 2, 12'h0, 32'h0);
    chk(rsp.imm_ext, 32'h0000_0200);
    $display("done pc");
  endtask
  task t_mmu;
    @(posedge clk);
    te <= 1'b1;
    ssm <= 1'b0;
    pehr <= 32'h1234_56ab;
    go(EAG_M_REG_IND, 2, 12'h0, 32'h40);
    chk(rsp.translate, 32'h1);
    chk(rsp.address_space_identifier_valid, 32'h1);
    chk(rsp.address_space_identifier, 32'hab);
    // code f is no mode: no address, so nothing goes to translation
    go(eag_mode_e'(4'hf), 2, 12'h0, 32'h40);
    chk(rsp.translate, 32'h0);
    chk(rsp.effective_address, 32'h0);
    @(posedge clk);
    ssm <= 1'b1;
    go(EAG_M_REG_IND, 2, 12'h0, 32'h40);
    chk(rsp.address_space_identifier_valid, 32'h0);
    @(posedge clk);
    te <= 1'b0;
    go(EAG_M_REG_IND, 2, 12'h0, 32'h40);
    chk(rsp.translate, 32'h0);
    $display("done mmu");
  endtask
  task give_verdict;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    issue = 1'b0;
    nreq = '0;
    r = '0;
    te = 1'b0;
    ssm = 1'b1;
    pehr = 32'h0;
    failures = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    t_basic;
    t_step;
    t_pc;
    t_mmu;
    give_verdict;
  end
  // 30 requests of 3 cycles; more than twelve times that covers slow tools
  initial
  begin
    #5000;
    failures++;
    give_verdict;
  end
endmodule // effective_address_generator_tb
`default_nettype wire
